// ==== pwc_pkg.sv ====
// Constants and types shared by the pulse width capture timer channel
package pwc_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned SEL_W  = 4;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [31:0] TIMER_CONTROL_IDX          = 32'hFFFF8260;
    localparam logic [31:0] CAPTURE_EDGE_CONTROL_IDX   = 32'hFFFF8262;
    localparam logic [31:0] TIMER_INTERRUPT_ENABLE_IDX = 32'hFFFF8264;
    localparam logic [31:0] TIMER_FLAG_REGISTER_IDX    = 32'hFFFF8265;
    localparam logic [31:0] CAPTURE_COUNTER_IDX        = 32'hFFFF8266;
    localparam logic [31:0] CAPTURE_VALUE_A_IDX        = 32'hFFFF8268;
    localparam logic [31:0] COUNTER_START_IDX          = 32'hFFFF8280;

    // Register widths and reset values
    localparam int unsigned REG8_W  = 8;
    localparam int unsigned CNT_W   = 16;
    localparam logic [7:0]  TIMER_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  EDGE_CONTROL_RST   = 8'h00;
    localparam logic [7:0]  INT_ENABLE_RST     = 8'h00;
    localparam logic [15:0] CAPTURE_VALUE_RST  = 16'h0000;
    localparam logic [15:0] CAPTURE_COUNT_RST  = 16'h0000;

    // Timer control fields: clear source and clock prescale
    localparam int unsigned CLEAR_SRC_LSB = 5;
    localparam int unsigned CLEAR_SRC_W   = 3;
    localparam logic [2:0]  CLEAR_ON_CAPTURE_A = 3'h1;
    localparam int unsigned PRESCALE_LSB  = 0;
    localparam int unsigned PRESCALE_SEL_W = 3;

    // Prescale selection codes and divider depth
    localparam logic [2:0]  PRESCALE_DIV1  = 3'h0;
    localparam logic [2:0]  PRESCALE_DIV4  = 3'h1;
    localparam logic [2:0]  PRESCALE_DIV16 = 3'h2;
    localparam logic [2:0]  PRESCALE_DIV64 = 3'h3;
    localparam int unsigned PRESCALE_W     = 6;
    localparam logic [5:0]  DIV4_MASK      = 6'h03;
    localparam logic [5:0]  DIV16_MASK     = 6'h0F;
    localparam logic [5:0]  DIV64_MASK     = 6'h3F;

    // Edge control field for channel A
    localparam int unsigned EDGE_A_LSB     = 0;
    localparam int unsigned EDGE_A_W       = 4;
    localparam int unsigned EDGE_CAPTURE_BIT = 3;
    localparam logic [1:0]  EDGE_CODE_RISE = 2'h0;
    localparam logic [1:0]  EDGE_CODE_FALL = 2'h1;

    // Interrupt enable, flag and start bit positions
    localparam int unsigned IEN_A_BIT     = 0;
    localparam int unsigned FLAG_A_BIT    = 0;
    localparam int unsigned START_BIT     = 0;

    // Byte lanes
    localparam int unsigned LANE0 = 0;
    localparam int unsigned LANE1 = 1;

    // Capture edge modes
    typedef enum logic [1:0] {
        EDGE_OFF,
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH
    } pwc_edge_type;

endpackage : pwc_pkg

// ==== pwc_edge_sync.sv ====
// Pin synchroniser and edge detector for the capture input
`timescale 1ns/1ps
module pwc_edge_sync (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic meta_d;
    logic sync_d;
    logic prev_d;

    // Next values of the three stages
    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Two flops guard against metastability; third holds the last level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // Edges seen only from the settled stages
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule : pwc_edge_sync

// ==== pwc_capture_timer.sv ====
// Pulse width capture timer channel with a classic Wishbone register slave
//
// Notes on behaviour
// - Control value selects clock, clears on capture
// - Selected pin edge copies counter into capture
// - Enabled capture raises the channel A interrupt
// - Capture holds width since previous edge
`timescale 1ns/1ps
module pwc_capture_timer #(
    parameter int unsigned COUNT_W = pwc_pkg::CNT_W
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [pwc_pkg::ADDR_W-1:0]  wb_adr_i,
    input  wire logic [pwc_pkg::DATA_W-1:0]  wb_dat_i,
    input  wire logic [pwc_pkg::SEL_W-1:0]   wb_sel_i,
    output logic      [pwc_pkg::DATA_W-1:0]  wb_dat_o,
    output logic                             wb_ack_o,
    input  wire logic                        capture_input_pin,
    output logic                             capture_a_interrupt
);
    import pwc_pkg::*;

    // Register hit test, used for every decode below
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr,
                                     input logic [31:0]       idx);
        reg_hit = (adr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction : reg_hit

    // Clear source decode, shared by the counter and the prescaler
    function automatic logic clears_on_capture(input logic [REG8_W-1:0] ctl);
        clears_on_capture = (ctl[CLEAR_SRC_LSB +: CLEAR_SRC_W] == CLEAR_ON_CAPTURE_A);
    endfunction : clears_on_capture

    // Merge a 16-bit register with the enabled byte lanes of a write
    function automatic logic [15:0] merge16(input logic [15:0]       old,
                                            input logic [DATA_W-1:0] dat,
                                            input logic [SEL_W-1:0]  sel);
        merge16 = old;
        if (sel[LANE0]) begin
            merge16[7:0] = dat[7:0];
        end
        if (sel[LANE1]) begin
            merge16[15:8] = dat[15:8];
        end
    endfunction : merge16

    // Decode the edge control field into a capture mode
    function automatic pwc_edge_type edge_mode(input logic [REG8_W-1:0] ctl);
        logic [EDGE_A_W-1:0] f;
        f = ctl[EDGE_A_LSB +: EDGE_A_W];
        if (!f[EDGE_CAPTURE_BIT]) begin
            edge_mode = EDGE_OFF;
        end else if (f[1:0] == EDGE_CODE_RISE) begin
            edge_mode = EDGE_RISE;
        end else if (f[1:0] == EDGE_CODE_FALL) begin
            edge_mode = EDGE_FALL;
        end else begin
            edge_mode = EDGE_BOTH;
        end
    endfunction : edge_mode

    // Bus state
    logic                 ack_q;
    logic                 ack_d;
    logic [DATA_W-1:0]    dat_q;
    logic [DATA_W-1:0]    dat_d;

    // Software registers
    logic [REG8_W-1:0]    timer_control_q;
    logic [REG8_W-1:0]    timer_control_d;
    logic [REG8_W-1:0]    capture_edge_control_q;
    logic [REG8_W-1:0]    capture_edge_control_d;
    logic [REG8_W-1:0]    timer_interrupt_enable_q;
    logic [REG8_W-1:0]    timer_interrupt_enable_d;
    logic                 counter_start_bit_q;
    logic                 counter_start_bit_d;

    // Timer state
    logic [COUNT_W-1:0]   capture_counter_q;
    logic [COUNT_W-1:0]   capture_counter_d;
    logic [COUNT_W-1:0]   capture_value_a_q;
    logic [COUNT_W-1:0]   capture_value_a_d;
    logic [PRESCALE_W-1:0] prescale_q;
    logic [PRESCALE_W-1:0] prescale_d;
    logic                 capture_a_flag_q;
    logic                 capture_a_flag_d;
    logic                 irq_q;
    logic                 irq_d;

    // Strobes and decoded controls
    logic                 commit_wr;
    logic                 wr_counter;
    logic                 wr_value_a;
    logic                 wr_flag_clear;
    logic                 capture_clear;
    logic                 pin_rise;
    logic                 pin_fall;
    logic                 capture_evt;
    logic                 count_tick;
    pwc_edge_type         mode;

    // Input pin passes two flops before any edge logic sees it
    pwc_edge_sync u_edge_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (capture_input_pin),
        .level   (),
        .rise    (pin_rise),
        .fall    (pin_fall)
    );

    // Write lands only on the edge where the master sees ack high
    assign commit_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;

    // Write strobes for registers that hardware also moves
    assign wr_counter    = commit_wr & reg_hit(wb_adr_i, CAPTURE_COUNTER_IDX);
    assign wr_value_a    = commit_wr & reg_hit(wb_adr_i, CAPTURE_VALUE_A_IDX);
    assign wr_flag_clear = commit_wr & wb_sel_i[LANE0] & ~wb_dat_i[FLAG_A_BIT]
                         & reg_hit(wb_adr_i, TIMER_FLAG_REGISTER_IDX);

    // Bus answer: ack one edge after the request, dropped right after
    always_comb begin
        ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
        dat_d = '0;
        if (reg_hit(wb_adr_i, TIMER_CONTROL_IDX)) begin
            dat_d[REG8_W-1:0] = timer_control_q;
        end else if (reg_hit(wb_adr_i, CAPTURE_EDGE_CONTROL_IDX)) begin
            dat_d[REG8_W-1:0] = capture_edge_control_q;
        end else if (reg_hit(wb_adr_i, TIMER_INTERRUPT_ENABLE_IDX)) begin
            dat_d[REG8_W-1:0] = timer_interrupt_enable_q;
        end else if (reg_hit(wb_adr_i, TIMER_FLAG_REGISTER_IDX)) begin
            dat_d[FLAG_A_BIT] = capture_a_flag_q;
        end else if (reg_hit(wb_adr_i, CAPTURE_COUNTER_IDX)) begin
            dat_d[COUNT_W-1:0] = capture_counter_q;
        end else if (reg_hit(wb_adr_i, CAPTURE_VALUE_A_IDX)) begin
            dat_d[COUNT_W-1:0] = capture_value_a_q;
        end else if (reg_hit(wb_adr_i, COUNTER_START_IDX)) begin
            dat_d[START_BIT] = counter_start_bit_q;
        end else begin
            dat_d = '0;     // Unmapped reads answer zero
        end
    end

    // Bus flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // Plain control registers; byte lane zero carries the 8-bit ones
    always_comb begin
        timer_control_d          = timer_control_q;
        capture_edge_control_d   = capture_edge_control_q;
        timer_interrupt_enable_d = timer_interrupt_enable_q;
        counter_start_bit_d      = counter_start_bit_q;
        if (commit_wr && wb_sel_i[LANE0]) begin
            if (reg_hit(wb_adr_i, TIMER_CONTROL_IDX)) begin
                timer_control_d = wb_dat_i[REG8_W-1:0];
            end else if (reg_hit(wb_adr_i, CAPTURE_EDGE_CONTROL_IDX)) begin
                capture_edge_control_d = wb_dat_i[REG8_W-1:0];
            end else if (reg_hit(wb_adr_i, TIMER_INTERRUPT_ENABLE_IDX)) begin
                timer_interrupt_enable_d = wb_dat_i[REG8_W-1:0];
            end else if (reg_hit(wb_adr_i, COUNTER_START_IDX)) begin
                counter_start_bit_d = wb_dat_i[START_BIT];
            end
        end
    end

    // Control register flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_control_q          <= TIMER_CONTROL_RST;
            capture_edge_control_q   <= EDGE_CONTROL_RST;
            timer_interrupt_enable_q <= INT_ENABLE_RST;
            counter_start_bit_q      <= 1'b0;
        end else begin
            timer_control_q          <= timer_control_d;
            capture_edge_control_q   <= capture_edge_control_d;
            timer_interrupt_enable_q <= timer_interrupt_enable_d;
            counter_start_bit_q      <= counter_start_bit_d;
        end
    end

    // Edge selection picks which pin transitions capture
    always_comb begin
        mode = edge_mode(capture_edge_control_q);
        case (mode)
            EDGE_RISE: capture_evt = pin_rise;
            EDGE_FALL: capture_evt = pin_fall;
            EDGE_BOTH: capture_evt = pin_rise | pin_fall;
            default:   capture_evt = 1'b0;
        endcase
    end

    // Counter clear strobe; capture and clear land on one edge
    assign capture_clear = capture_evt & clears_on_capture(timer_control_q);

    // Prescaler; divided rates tick when the low bits wrap, restart on a clear
    always_comb begin
        if (capture_clear) begin
            prescale_d = '0;
        end else if (counter_start_bit_q) begin
            prescale_d = prescale_q + 1'b1;
        end else begin
            prescale_d = prescale_q;
        end
        case (timer_control_q[PRESCALE_LSB +: PRESCALE_SEL_W])
            PRESCALE_DIV1:  count_tick = 1'b1;
            PRESCALE_DIV4:  count_tick = (prescale_q & DIV4_MASK) == DIV4_MASK;
            PRESCALE_DIV16: count_tick = (prescale_q & DIV16_MASK) == DIV16_MASK;
            PRESCALE_DIV64: count_tick = (prescale_q & DIV64_MASK) == DIV64_MASK;
            default:        count_tick = 1'b1;
        endcase
        count_tick = count_tick & counter_start_bit_q;
    end

    // Counter and capture; the capture clear beats a software write
    always_comb begin
        capture_counter_d = capture_counter_q;
        capture_value_a_d = capture_value_a_q;
        if (wr_counter) begin
            capture_counter_d = COUNT_W'(merge16(capture_counter_q, wb_dat_i, wb_sel_i));
        end else if (count_tick) begin
            capture_counter_d = capture_counter_q + 1'b1;
        end
        if (wr_value_a) begin
            capture_value_a_d = COUNT_W'(merge16(capture_value_a_q, wb_dat_i, wb_sel_i));
        end
        if (capture_evt) begin
            capture_value_a_d = capture_counter_q;
        end
        if (capture_clear) begin
            capture_counter_d = '0;
        end
    end

    // Counter and capture flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capture_counter_q <= CAPTURE_COUNT_RST;
            capture_value_a_q <= CAPTURE_VALUE_RST;
        end else begin
            capture_counter_q <= capture_counter_d;
            capture_value_a_q <= capture_value_a_d;
        end
    end

    // Prescaler flop; cleared with the counter so divided widths stay aligned
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prescale_q <= '0;
        end else begin
            prescale_q <= prescale_d;
        end
    end

    // Flag: writing zero clears it, a capture in the same cycle wins
    always_comb begin
        capture_a_flag_d = capture_a_flag_q;
        if (wr_flag_clear) begin
            capture_a_flag_d = 1'b0;
        end
        if (capture_evt) begin
            capture_a_flag_d = 1'b1;
        end
    end

    // Request next value; uses next flag and enable so it never lags the flag
    always_comb begin
        irq_d = capture_a_flag_d & timer_interrupt_enable_d[IEN_A_BIT];
    end

    // Request follows the flag in the same cycle, from a flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            capture_a_flag_q <= 1'b0;
            irq_q            <= 1'b0;
        end else begin
            capture_a_flag_q <= capture_a_flag_d;
            irq_q            <= irq_d;
        end
    end

    assign capture_a_interrupt = irq_q;

endmodule : pwc_capture_timer

// ==== pwc_checker.sv ====
// Bus and interrupt timing checks for the pulse width capture channel
`timescale 1ns/1ps
module pwc_checker #(
    parameter int unsigned COUNT_W      = 16,
    parameter logic [31:0] UNMAPPED_ADR = 32'h0000_0100
) (
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       wb_cyc_i,
    input wire logic                       wb_stb_i,
    input wire logic                       wb_we_i,
    input wire logic [pwc_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [pwc_pkg::DATA_W-1:0] wb_dat_i,
    input wire logic [pwc_pkg::SEL_W-1:0]  wb_sel_i,
    input wire logic [pwc_pkg::DATA_W-1:0] wb_dat_o,
    input wire logic                       wb_ack_o,
    input wire logic                       capture_input_pin,
    input wire logic                       capture_a_interrupt
);
    import pwc_pkg::*;
    logic wr_hit;

    // Committed write; only software may move the interrupt apart from a pin edge
    assign wr_hit = wb_ack_o && wb_we_i;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered after one cycle");
    a_ack_needs_request: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    a_unmapped_reads_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
        && wb_adr_i == UNMAPPED_ADR |=> wb_dat_o == '0)
        else $error("unmapped read not zero");
    a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[DATA_W-1:COUNT_W] == '0)
        else $error("read data above register width not zero");
    a_irq_rise_cause: assert property ($rose(capture_a_interrupt) |->
        $past(capture_input_pin, 3) != $past(capture_input_pin, 4)
        || $past(wr_hit) || $past(wr_hit, 2))
        else $error("interrupt rose without pin edge or enable write");
    a_irq_fall_cause: assert property ($fell(capture_a_interrupt) |->
        $past(wr_hit) || $past(wr_hit, 2))
        else $error("interrupt fell without a flag clear");
    a_reset_quiet: assert property ($fell(rst) |-> !capture_a_interrupt && !wb_ack_o)
        else $error("outputs active at reset release");
endmodule : pwc_checker

bind pwc_capture_timer pwc_checker #(.COUNT_W(COUNT_W)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .capture_input_pin(capture_input_pin),
    .capture_a_interrupt(capture_a_interrupt)
);

// ==== pwc_pulse_src.sv ====
// External pulse source driving the capture input pin
`timescale 1ns/1ps
module pwc_pulse_src (
    input  wire logic        sys_clk,
    input  wire logic        run,
    input  wire logic [15:0] hi_w,
    input  wire logic [15:0] lo_w,
    output logic             pin
);
    logic [15:0] left_q;

    initial pin = 1'b0;

    // Width latched at each phase start, so a new width waits one phase
    always @(posedge sys_clk) begin
        if (!run) begin
            pin    <= 1'b0;
            left_q <= 16'h0001;
        end else if (left_q == 16'h0001) begin
            pin    <= ~pin;
            left_q <= pin ? lo_w : hi_w;
        end else begin
            left_q <= left_q - 16'h0001;
        end
    end
endmodule : pwc_pulse_src

// ==== pwc_capture_timer_tb.sv ====
// Self-checking bench for the pulse width capture channel
`timescale 1ns/1ps
module pwc_capture_timer_tb;
    import pwc_pkg::*;
    logic        sys_clk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [31:0] dat_w;
    logic [3:0]  sel;
    logic [31:0] dat_r;
    logic        ack;
    logic        irq;
    logic        pin;
    logic        run;
    logic [15:0] hi_w;
    logic [15:0] lo_w;
    logic [15:0] w_r;
    logic [31:0] rd;
    integer      seed;
    int          err_total;
    int          total_checks;

    pwc_capture_timer DUT (
        .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_dat_o(dat_r),
        .wb_ack_o(ack), .capture_input_pin(pin), .capture_a_interrupt(irq)
    );
    pwc_pulse_src u_src (.sys_clk(sys_clk), .run(run), .hi_w(hi_w), .lo_w(lo_w), .pin(pin));

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    // Clear at the capture edge costs one count; widths are in clock periods
    function automatic logic [31:0] expect_count(input logic [15:0] w);
        return {16'h0, w} - 32'h1;
    endfunction : expect_count

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic give_up(input string what);
        err_total++;
        $display("unexpected %s: expected an answer, seen a timeout", what);
        report_and_stop();
    endtask : give_up

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check_val

    // Classic single cycle; request held until ack is sampled high
    task automatic bus(input logic w, input logic [31:0] idx, input logic [31:0] d);
        int n;
        n = 0;
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= idx << 2;
        dat_w <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) give_up("wb_ack_o");
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic rd_chk(input logic [31:0] idx, input logic [31:0] exp, input string what);
        bus(1'b0, idx, 32'h0);
        check_val(what, exp, rd);
    endtask : rd_chk

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2000) begin // Request must rise within 2000 cycles or the bench gives up
            @(posedge sys_clk);
            n++;
        end
        if (n >= 2000) give_up("capture_a_interrupt");
    endtask : wait_irq

    // Software handler: clear flag, check width by edge, flip edge
    task automatic handler(input logic chk);
        logic rising;
        wait_irq();
        bus(1'b1, TIMER_FLAG_REGISTER_IDX, 32'h0);
        bus(1'b0, CAPTURE_EDGE_CONTROL_IDX, 32'h0);
        rising = (rd[3:0] == 4'h8);
        check_val("cleared irq", 32'h0, {31'h0, irq});
        bus(1'b0, CAPTURE_VALUE_A_IDX, 32'h0);
        if (chk) check_val("capture_value_a", expect_count(rising ? lo_w : hi_w), rd);
        bus(1'b1, CAPTURE_EDGE_CONTROL_IDX, rising ? 32'h09 : 32'h08);
    endtask : handler

    // Main sequence
    initial begin
        seed = 32'h6c93;
        sys_clk = 1'b0;
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0;
        dat_w = 32'h0;
        sel = 4'hF;
        run = 1'b0;
        hi_w = 16'h0032;
        lo_w = 16'h0032;
        err_total = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0; // Block live before any configuration
        @(posedge sys_clk);
        rd_chk(TIMER_CONTROL_IDX, 32'h0, "timer_control reset");
        rd_chk(CAPTURE_COUNTER_IDX, 32'h0, "capture_counter reset");
        rd_chk(32'h0000_0040, 32'h0, "unmapped read");
        bus(1'b1, TIMER_CONTROL_IDX, 32'h20);
        rd_chk(TIMER_CONTROL_IDX, 32'h20, "timer_control");
        bus(1'b1, CAPTURE_EDGE_CONTROL_IDX, 32'h08);
        bus(1'b1, TIMER_INTERRUPT_ENABLE_IDX, 32'h40);
        rd_chk(TIMER_INTERRUPT_ENABLE_IDX, 32'h40, "timer_interrupt_enable");
        run <= 1'b1; // Pulse reaches the capture pin before measuring
        bus(1'b1, COUNTER_START_IDX, 32'h1);
        // Source period is known here, so a fixed wait covers the first rise
        repeat (120) @(posedge sys_clk);
        check_val("masked irq", 32'h0, {31'h0, irq});
        bus(1'b0, TIMER_FLAG_REGISTER_IDX, 32'h0);
        check_val("capture_a_flag", 32'h1, rd & 32'h1);
        bus(1'b1, TIMER_INTERRUPT_ENABLE_IDX, 32'h41);
        for (int s = 0; s < 6; s++) begin
            hi_w <= (s == 0) ? 16'd40 : 16'(40 + {$random(seed)} % 160);
            lo_w <= (s == 1) ? 16'd40 : 16'(40 + {$random(seed)} % 160);
            for (int k = 0; k < 6; k++) handler(k >= 4);
        end
        // Both edges on a divide-by-four clock; equal widths make every capture alike
        bus(1'b1, TIMER_CONTROL_IDX, 32'h21);
        bus(1'b1, CAPTURE_EDGE_CONTROL_IDX, 32'hFF);
        w_r = 16'(40 + {$random(seed)} % 160);
        hi_w <= w_r;
        lo_w <= w_r;
        for (int k = 0; k < 6; k++) begin
            wait_irq();
            bus(1'b1, TIMER_FLAG_REGISTER_IDX, 32'h0);
            bus(1'b0, CAPTURE_VALUE_A_IDX, 32'h0);
            // Counter ticks once per four clocks from the clear
            if (k >= 3) check_val("div capture", expect_count(w_r) >> 2, rd);
        end
        bus(1'b1, CAPTURE_EDGE_CONTROL_IDX, 32'h01);
        run <= 1'b0;
        bus(1'b1, COUNTER_START_IDX, 32'h0);
        bus(1'b1, CAPTURE_COUNTER_IDX, 32'h1234);
        repeat (4) @(posedge sys_clk);
        rd_chk(CAPTURE_COUNTER_IDX, 32'h1234, "stopped capture_counter");
        report_and_stop();
    end
endmodule : pwc_capture_timer_tb
